// ===== verilog/tpc_consts.svh
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// register byte addresses, one aligned word each
`define TPC_ADDR_STATUS_CONTROL 8'h00
`define TPC_ADDR_COUNT_HIGH     8'h04
`define TPC_ADDR_COUNT_LOW      8'h08
`define TPC_ADDR_LIMIT_HIGH     8'h0C
`define TPC_ADDR_LIMIT_LOW      8'h10

// status/control field positions
`define TPC_BIT_OVF      7
`define TPC_BIT_IRQ_EN   6
`define TPC_BIT_CENTER   5
`define TPC_CLKS_MSB     4
`define TPC_CLKS_LSB     3
`define TPC_PS_MSB       2
`define TPC_PS_LSB       0

// reset values
`define TPC_RST_CTRL     8'h00
`define TPC_RST_COUNT    16'h0000
`define TPC_RST_LIMIT    16'h0000
// limit that stands for the full 16-bit range
`define TPC_LIMIT_FULL   16'hFFFF
`define TPC_PRESC_WIDTH  7

`endif

// ===== verilog/tpc_pkg.sv
`default_nettype none
package tpc_pkg;

    // control fields of the status/control register
    typedef struct packed {
        logic       irq_en;
        logic       center;
        logic [1:0] clks;
        logic [2:0] ps;
    } tpc_ctrl_s;

    // clock source selection codes
    typedef enum logic [1:0] {
        TPC_SRC_NONE  = 2'h0,
        TPC_SRC_BUS   = 2'h1,
        TPC_SRC_FIXED = 2'h2,
        TPC_SRC_EXT   = 2'h3
    } tpc_src_e;

    // counting direction, one-hot
    typedef enum logic [1:0] {
        TPC_DIR_UP   = 2'b01,
        TPC_DIR_DOWN = 2'b10
    } tpc_dir_e;

endpackage
`default_nettype wire

// ===== verilog/tpc_core.sv
// Functional notes
// - up mode sets overflow flag when counter wraps to zero after limit.
// - center mode sets overflow flag when turning down after reaching limit.
// - flag clears only by status read while set, then writing zero.
// - overflow during clear sequence restarts it so flag stays set.
// - writing one to flag does nothing; reset clears flag.
// - interrupt request is flag and interrupt enable together.
// - center select zero counts up; one counts up/down, channels center-aligned.
// - clock source field picks none, bus, fixed or external clock.
// - fixed and external clocks pass a bus-clock synchroniser first.
// - prescale field divides selected clock by two to its value.
// - prescaler follows selection and synchronisation.
// - reading either count byte freezes both until other byte read.
// - reset, count writes and status writes re-arm the read latch.
// - count bytes read-only as data; reset clears counter.
// - debug mode halts counter and freezes latch state against reads.
// - at limit restart from zero, or count down in center mode.
// - writing one limit byte blocks overflow until other byte written.
// - reset limit is zero, meaning full free-running range.
// - reset clears interrupt enable and center select.
// - limit of all ones also runs the full range.
// - any write to a count byte clears the counter.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.svh"

module tpc_core
    import tpc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fixed_clk_in,
    input  wire logic        ext_clk_in,
    input  wire logic        debug_active,
    output var  logic [15:0] count_value,
    output logic             count_down,
    output logic             center_align_select,
    output logic             overflow_irq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    tpc_ctrl_s       ctrl_reg;
    logic            overflow_flag_reg;
    logic            clear_armed_reg;
    logic [15:0]     count_reg;
    logic [15:0]     limit_reg;
    logic [1:0]      limit_half_reg;  // bit0: low written, bit1: high written
    tpc_dir_e        dir_reg;
    logic [15:0]     hold_reg;
    logic            hold_valid_reg;
    logic            hold_low_left_reg;
    logic [`TPC_PRESC_WIDTH-1:0] presc_reg;
    logic [2:0]      fixed_sync_reg;
    logic [2:0]      ext_sync_reg;
    logic            pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic            setup_rd;
    logic            acc_wr;
    logic            addr_ok;
    logic            sel_sc;
    logic            sel_ch;
    logic            sel_cl;
    logic            sel_lh;
    logic            sel_ll;

    assign sel_sc  = (paddr == `TPC_ADDR_STATUS_CONTROL);
    assign sel_ch  = (paddr == `TPC_ADDR_COUNT_HIGH);
    assign sel_cl  = (paddr == `TPC_ADDR_COUNT_LOW);
    assign sel_lh  = (paddr == `TPC_ADDR_LIMIT_HIGH);
    assign sel_ll  = (paddr == `TPC_ADDR_LIMIT_LOW);
    assign addr_ok = sel_sc | sel_ch | sel_cl | sel_lh | sel_ll;

    // reads act in the setup cycle so data and latch capture agree
    assign setup_rd = clk_en & psel & ~penable & ~pwrite;
    // writes take effect at the completing access edge
    assign acc_wr   = clk_en & psel & penable & pwrite & addr_ok;

    // zero wait states; a frozen block stalls the bus instead
    assign pready  = psel & penable & clk_en;
    // error is registered at setup so it stands through the whole access
    assign pslverr = pslverr_reg;

    // error flag computed in setup, shown during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (clk_en && psel && !penable) begin
            pslverr_reg <= ~addr_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock source synchronisers and selection
    logic src_tick;
    logic fixed_rise;
    logic ext_rise;

    // only stage 1 and 2 feed the edge detector, stage 0 is metastable
    // a third stage costs a cycle of latency but gives a glitch-free edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_sync_reg <= 3'h0;
            ext_sync_reg   <= 3'h0;
        end else if (clk_en) begin
            fixed_sync_reg <= {fixed_sync_reg[1:0], fixed_clk_in};
            ext_sync_reg   <= {ext_sync_reg[1:0], ext_clk_in};
        end
    end

    assign fixed_rise = fixed_sync_reg[1] & ~fixed_sync_reg[2];
    assign ext_rise   = ext_sync_reg[1] & ~ext_sync_reg[2];

    // source pick; external limited to half of pclk by the synchroniser
    // bus source ticks every enabled cycle, so divide-by-1 counts at pclk
    always_comb begin
        case (tpc_src_e'(ctrl_reg.clks))
            TPC_SRC_NONE:  src_tick = 1'b0;
            TPC_SRC_BUS:   src_tick = 1'b1;
            TPC_SRC_FIXED: src_tick = fixed_rise;
            TPC_SRC_EXT:   src_tick = ext_rise;
            default:       src_tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler after selection
    logic [`TPC_PRESC_WIDTH-1:0] presc_mask;
    logic                        count_tick;
    logic                        run;

    assign run        = clk_en & ~debug_active;
    assign presc_mask = `TPC_PRESC_WIDTH'((8'h01 << ctrl_reg.ps) - 8'h01);
    // pulse on the last source tick of each 2^ps group
    // never cleared: a new divisor may give one short first period
    assign count_tick = run & src_tick & ((presc_reg & presc_mask) == presc_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= '0;
        end else if (run && src_tick) begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter and direction
    logic [15:0] limit_eff;
    logic        at_limit;
    logic        ovf_event;
    logic        count_wr;

    // zero limit means full range
    assign limit_eff = (limit_reg == `TPC_RST_LIMIT) ? `TPC_LIMIT_FULL : limit_reg;
    assign at_limit  = (count_reg == limit_eff);
    assign count_wr  = acc_wr & (sel_ch | sel_cl);
    // overflow is the limit step, suppressed while the limit is half written
    // a count write on the limit step wins, so no flag for a cleared counter
    assign ovf_event = count_tick & at_limit & (dir_reg == TPC_DIR_UP) &
                       (limit_half_reg == 2'b00) & ~count_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `TPC_RST_COUNT;
        end else if (count_wr) begin
            count_reg <= `TPC_RST_COUNT;
        end else if (count_tick) begin
            if (!ctrl_reg.center) begin
                count_reg <= at_limit ? `TPC_RST_COUNT : count_reg + 16'h0001;
            end else if (dir_reg == TPC_DIR_UP) begin
                // turn at the limit: next step is already one lower
                count_reg <= at_limit ? count_reg - 16'h0001 : count_reg + 16'h0001;
            end else begin
                count_reg <= (count_reg == 16'h0000) ? 16'h0001 : count_reg - 16'h0001;
            end
        end
    end

    // direction machine; up-only outside center mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= TPC_DIR_UP;
        end else if (clk_en && (count_wr || !ctrl_reg.center)) begin
            // gated so a frozen block keeps its direction as well
            dir_reg <= TPC_DIR_UP;
        end else if (count_tick) begin
            case (dir_reg)
                TPC_DIR_UP:   if (at_limit) dir_reg <= TPC_DIR_DOWN;
                TPC_DIR_DOWN: if (count_reg == 16'h0000) dir_reg <= TPC_DIR_UP;
                default:      dir_reg <= TPC_DIR_UP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tpc_ctrl_s'(7'(`TPC_RST_CTRL));
        end else if (acc_wr && sel_sc) begin
            ctrl_reg.irq_en <= pwdata[`TPC_BIT_IRQ_EN];
            ctrl_reg.center <= pwdata[`TPC_BIT_CENTER];
            ctrl_reg.clks   <= pwdata[`TPC_CLKS_MSB:`TPC_CLKS_LSB];
            ctrl_reg.ps     <= pwdata[`TPC_PS_MSB:`TPC_PS_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flag with two-step clear
    logic sc_clear;

    assign sc_clear = acc_wr & sel_sc & clear_armed_reg & ~pwdata[`TPC_BIT_OVF];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag_reg <= 1'b1;
        end else if (sc_clear) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // arming: status read while set; any new overflow disarms
    // overflow on the arming edge leaves it disarmed, so the flag survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_armed_reg <= 1'b0;
        end else if (ovf_event) begin
            clear_armed_reg <= 1'b0;
        end else if (acc_wr && sel_sc) begin
            clear_armed_reg <= 1'b0;
        end else if (setup_rd && sel_sc && overflow_flag_reg) begin
            clear_armed_reg <= 1'b1;
        end
    end

    assign overflow_irq = overflow_flag_reg & ctrl_reg.irq_en;

    ////////////////////////////////////////////////////////////////////////
    // limit register and half-written guard
    // the same half written twice keeps the guard open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_reg      <= `TPC_RST_LIMIT;
            limit_half_reg <= 2'b00;
        end else if (acc_wr && sel_lh) begin
            limit_reg[15:8] <= pwdata[7:0];
            // second half completes the pair, first half opens it
            limit_half_reg  <= limit_half_reg[0] ? 2'b00 : 2'b10;
        end else if (acc_wr && sel_ll) begin
            limit_reg[7:0]  <= pwdata[7:0];
            limit_half_reg  <= limit_half_reg[1] ? 2'b00 : 2'b01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // coherent count reads
    logic rd_ch;
    logic rd_cl;

    // debug freezes the latch even on reads
    // writes outrank reads so a re-armed latch starts empty
    assign rd_ch = setup_rd & sel_ch & ~debug_active;
    assign rd_cl = setup_rd & sel_cl & ~debug_active;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_valid_reg    <= 1'b0;
            hold_low_left_reg <= 1'b0;
            hold_reg          <= `TPC_RST_COUNT;
        end else if (acc_wr && (sel_sc || sel_ch || sel_cl)) begin
            hold_valid_reg <= 1'b0;
        end else if (!hold_valid_reg && (rd_ch || rd_cl)) begin
            hold_reg          <= count_reg;
            hold_valid_reg    <= 1'b1;
            hold_low_left_reg <= rd_ch;
        end else if (hold_valid_reg && ((rd_cl && hold_low_left_reg) ||
                                        (rd_ch && !hold_low_left_reg))) begin
            hold_valid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the setup cycle
    // only the low byte carries data; upper bits read as zero
    logic [15:0] count_view;
    logic [7:0]  rd_byte;

    assign count_view = hold_valid_reg ? hold_reg : count_reg;

    always_comb begin
        rd_byte = 8'h00;
        if (sel_sc) begin
            rd_byte = {overflow_flag_reg, ctrl_reg.irq_en, ctrl_reg.center,
                       ctrl_reg.clks, ctrl_reg.ps};
        end else if (sel_ch) begin
            rd_byte = count_view[15:8];
        end else if (sel_cl) begin
            rd_byte = count_view[7:0];
        end else if (sel_lh) begin
            rd_byte = limit_reg[15:8];
        end else if (sel_ll) begin
            rd_byte = limit_reg[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core outputs to channel logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= `TPC_RST_COUNT;
        end else if (clk_en) begin
            count_value <= count_reg;
        end
    end

    assign count_down          = (dir_reg == TPC_DIR_DOWN);
    assign center_align_select = ctrl_reg.center;

endmodule
`default_nettype wire

// ===== verification/tpc_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.svh"

module tpc_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        debug_active,
    input wire logic [15:0] count_value,
    input wire logic        count_down,
    input wire logic        center_align_select,
    input wire logic        overflow_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // bus access phases that touch control or count bytes
    sequence ctl_write_s;
        psel && penable && pwrite && clk_en && paddr == `TPC_ADDR_STATUS_CONTROL;
    endsequence
    sequence cnt_write_s;
        psel && penable && pwrite && clk_en
            && (paddr == `TPC_ADDR_COUNT_HIGH || paddr == `TPC_ADDR_COUNT_LOW);
    endsequence

    ////////////////////////////////////////////////////////////////
    // bus answer
    ready_follows_a: assert property (pready == (psel && penable && clk_en))
        else $error("pready does not follow the access phase");
    unmapped_err_a: assert property (
        psel && !penable && clk_en && paddr > `TPC_ADDR_LIMIT_LOW |=> pslverr)
        else $error("no error on unmapped access");

    ////////////////////////////////////////////////////////////////
    // counter motion: one step at a time, or a clear (wrap included)
    count_step_a: assert property (
        $changed(count_value) |-> count_value == 16'($past(count_value) + 16'h0001)
            || count_value == 16'($past(count_value) - 16'h0001) || count_value == 16'h0000)
        else $error("counter jumped");
    debug_hold_a: assert property (
        (debug_active && clk_en) [*3] |-> $stable(count_value))
        else $error("counter moved in debug");
    down_cause_a: assert property ($rose(count_down) |-> center_align_select)
        else $error("down count outside center mode");
    irq_fall_a: assert property (
        $fell(overflow_irq) |-> $past(psel && penable && pwrite && clk_en && paddr == 8'h00))
        else $error("overflow request dropped without a control write");
    cnt_clear_a: assert property (cnt_write_s ##1 clk_en |=> count_value == 16'h0000)
        else $error("count write did not clear");
    reset_clear_a: assert property (
        $rose(presetn) |-> count_value == 16'h0000 && !overflow_irq
            && !center_align_select && !count_down)
        else $error("state not cleared by reset");
    ctrl_load_a: assert property (
        ctl_write_s |=> center_align_select == $past(pwdata[`TPC_BIT_CENTER]))
        else $error("center select not loaded by control write");
endmodule

`default_nettype wire

// ===== verification/tpc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.svh"

module tpc_core_test
    import tpc_pkg::*;
;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic        fix_clk = 0, ext_clk = 0, dbg = 0, err, pslverr, pready, down, center, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [15:0] cnt;
    int          n_errors = 0, compares = 0, cyc = 0;

    tpc_core dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fixed_clk_in(fix_clk), .ext_clk_in(ext_clk), .debug_active(dbg),
        .count_value(cnt), .count_down(down), .center_align_select(center),
        .overflow_irq(irq));

    // clock and hang guard
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s: %h not %h", $time, msg, seen, exp);
        end
    endtask

    // one transfer; upper data bits are random since the block ignores them
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= ($urandom() & 32'hFFFF_FF00) | {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic clear();
        apb(1'b1, $urandom_range(1, 0) ? `TPC_ADDR_COUNT_HIGH : `TPC_ADDR_COUNT_LOW,
            8'($urandom()));
    endtask

    task automatic rd_cnt(output logic [15:0] v);
        apb(1'b0, `TPC_ADDR_COUNT_HIGH, 8'h00);
        v[15:8] = rd[7:0];
        apb(1'b0, `TPC_ADDR_COUNT_LOW, 8'h00);
        v[7:0] = rd[7:0];
    endtask

    // the two control writes bracket exactly w + 3 counting edges
    task automatic run(input logic [7:0] ctl, input int w);
        apb(1'b1, `TPC_ADDR_STATUS_CONTROL, ctl);
        repeat (w) @(posedge pclk);
        apb(1'b1, `TPC_ADDR_STATUS_CONTROL, ctl & 8'hE7);
    endtask

    // arming read then write; wait for the write to land before looking
    task automatic flag_clear(input logic [7:0] ctl);
        apb(1'b0, `TPC_ADDR_STATUS_CONTROL, 8'h00);
        apb(1'b1, `TPC_ADDR_STATUS_CONTROL, ctl);
        @(negedge pclk);
    endtask

    function automatic logic [15:0] exp_count(input int d, input int lim, input logic ctr);
        int p;
        if (!ctr) return 16'(d % (lim + 1));
        p = d % (2 * lim);
        return 16'((p <= lim) ? p : 2 * lim - p);
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] v;
        int          lim, d, k, q;
        void'($urandom(32'h8a32c9f2));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 8'h00);
            check(rd, 32'h0000_0000, "reset value");
        end
        apb(1'b0, 8'h14, 8'h00);
        check({rd[30:0], err}, 32'h0000_0001, "unmapped read");
        $display("reset test done");
        // every divisor on the bus clock, then no source at all
        for (int p = 0; p < 8; p++) begin
            k = $urandom_range(6, 3);
            clear();
            run(8'h08 | 8'(p), (k << p) - 3);
            rd_cnt(v);
            check(32'(v), 32'(k), "prescaled count");
        end
        clear();
        repeat (20) @(posedge pclk);
        check(32'(cnt), 32'h0000_0000, "stopped count");
        // synchronised sources, pulsed well under a quarter of the bus rate
        for (int s = 2; s < 4; s++) begin
            k = $urandom_range(5, 2);
            clear();
            // no channel claims the clock pin while it is a source
            apb(1'b1, `TPC_ADDR_STATUS_CONTROL, 8'(s << 3) | 8'(s - 2));
            repeat (k << (s - 2)) begin
                repeat (4) @(posedge pclk);
                if (s == 2) fix_clk <= 1'b1; else ext_clk <= 1'b1;
                repeat (4) @(posedge pclk);
                fix_clk <= 1'b0;
                ext_clk <= 1'b0;
            end
            repeat (8) @(posedge pclk);
            apb(1'b1, `TPC_ADDR_STATUS_CONTROL, 8'h00);
            rd_cnt(v);
            check(32'(v), 32'(k), "synced source count");
        end
        $display("clock source test done");
        // limit, wrap or turnaround, and the flag clearing protocol
        for (int c = 0; c < 2; c++) begin
            lim = $urandom_range(12, 3);
            d = $urandom_range(3 * lim, lim + 1);
            apb(1'b1, `TPC_ADDR_LIMIT_HIGH, 8'h00);
            apb(1'b1, `TPC_ADDR_LIMIT_LOW, 8'(lim));
            clear();
            run(8'h48 | 8'(c << 5), d - 3);
            rd_cnt(v);
            check(32'(v), 32'(exp_count(d, lim, c[0])), "limited count");
            q = d % (2 * lim);
            check(32'(center), 32'(c), "center select");
            check(32'(down), 32'(c == 1 && (q == 0 || q > lim)), "count direction");
            check(32'(irq), 32'd1, "overflow request");
            flag_clear(8'hC0 | 8'(c << 5));
            check(32'(irq), 32'd1, "flag after writing one");
            flag_clear(8'h40 | 8'(c << 5));
            check(32'(irq), 32'd0, "flag after clear");
        end
        apb(1'b1, `TPC_ADDR_LIMIT_LOW, 8'(lim));
        clear();
        run(8'h48, lim + 4);
        check(32'(irq), 32'd0, "overflow with half written limit");
        apb(1'b1, `TPC_ADDR_LIMIT_HIGH, 8'h00);
        clear();
        run(8'h48, lim + 4);
        check(32'(irq), 32'd1, "overflow after both bytes");
        // short period: an overflow always falls between arm and clear
        clear();
        apb(1'b1, `TPC_ADDR_LIMIT_LOW, 8'h02);
        apb(1'b1, `TPC_ADDR_LIMIT_HIGH, 8'h00);
        apb(1'b1, `TPC_ADDR_STATUS_CONTROL, 8'h48);
        flag_clear(8'h48);
        check(32'(irq), 32'd1, "flag kept by late overflow");
        apb(1'b1, `TPC_ADDR_STATUS_CONTROL, 8'h40);
        flag_clear(8'h40);
        check(32'(irq), 32'd0, "flag cleared when quiet");
        $display("overflow test done");
        // frozen pair: high byte read long after the low byte
        apb(1'b1, `TPC_ADDR_LIMIT_LOW, 8'h00);
        clear();
        apb(1'b1, `TPC_ADDR_STATUS_CONTROL, 8'h08);
        apb(1'b0, `TPC_ADDR_COUNT_LOW, 8'h00);
        repeat (600) @(posedge pclk);
        apb(1'b0, `TPC_ADDR_COUNT_HIGH, 8'h00);
        check(rd, 32'h0000_0000, "latched high byte");
        @(posedge pclk);
        dbg <= 1'b1;
        repeat (3) @(negedge pclk);
        v = cnt;
        repeat (10) @(negedge pclk);
        check(32'(cnt), 32'(v), "halted count");
        @(posedge pclk);
        dbg <= 1'b0;
        $display("coherency and debug test done");
        close_out();
    end
endmodule

bind tpc_core tpc_asserts chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr),
    .debug_active(debug_active), .count_value(count_value), .count_down(count_down),
    .center_align_select(center_align_select), .overflow_irq(overflow_irq));

`default_nettype wire
